/* hdl/pcd_in_sync.sv */
/*
 * Two-stage synchroniser for a vector of boolean inputs, followed by a
 * third stage used only to find rising and falling edges.
 * Assumes asynchronous inputs and a synchronous active-low reset.
 */
`default_nettype none
module pcd_in_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Raw inputs
   input  wire logic [WIDTH-1:0] din,
   // Synchronised level and edges
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] last_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '0;
         sync_r <= '0;
         last_r <= '0;
      end else begin
         meta_r <= din;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign rise  = sync_r & ~last_r;
   assign fall  = ~sync_r & last_r;
endmodule
`default_nettype wire

/* hdl/pcd_pkg.sv */
/*
 * Shared constants of the pulse counter and delay timer block: register
 * offsets, reset values, input bit positions and time base figures.
 * Assumes a 100 MHz system clock and 32-bit AXI4-Lite register access.
 */
`default_nettype none
package pcd_pkg;
   localparam int          ADDR_W          = 6;
   localparam int          VAL_W           = 16;
   localparam int          NUM_PRESET      = 6;
   localparam int          NUM_IN          = 13;

   // Register byte offsets
   localparam logic [5:0]  OFS_CTRL        = 6'h00;
   localparam logic [5:0]  OFS_PRESET_BASE = 6'h04;
   localparam logic [5:0]  OFS_STATUS      = 6'h1c;
   localparam logic [5:0]  OFS_DN_ACC      = 6'h20;
   localparam logic [5:0]  OFS_UP_ACC      = 6'h24;
   localparam logic [5:0]  OFS_OF_ACC      = 6'h28;

   // Preset slots, in offset order from OFS_PRESET_BASE
   localparam int          PS_DN           = 0;
   localparam int          PS_UP           = 1;
   localparam int          PS_CU           = 2;
   localparam int          PS_OF           = 3;
   localparam int          PS_COF          = 4;
   localparam int          PS_ON           = 5;

   // Control bits: take preset from the external preset input
   localparam int          CTRL_DN_EXT     = 0;
   localparam int          CTRL_UP_EXT     = 1;
   localparam int          CTRL_OF_EXT     = 2;
   localparam int          CTRL_ON_EXT     = 3;
   localparam logic [3:0]  CTRL_RST        = 4'h0;
   localparam logic [15:0] PRESET_RST      = 16'h000a;
   localparam logic [15:0] ACC_MAX         = 16'hffff;

   // Synchronised input positions
   localparam int          IN_DN_EN        = 0;
   localparam int          IN_DN_PULSE     = 1;
   localparam int          IN_DN_RST       = 2;
   localparam int          IN_UP_EN        = 3;
   localparam int          IN_UP_PULSE     = 4;
   localparam int          IN_UP_RST       = 5;
   localparam int          IN_CU_EN        = 6;
   localparam int          IN_CU_PULSE     = 7;
   localparam int          IN_OF_EN        = 8;
   localparam int          IN_OF_IN        = 9;
   localparam int          IN_COF_IN       = 10;
   localparam int          IN_ON_EN        = 11;
   localparam int          IN_ON_IN        = 12;

   // Time base
   localparam int          CLK_PERIOD_NS   = 10;
   localparam int          TICK_PERIOD_MS  = 10;
   localparam int          TICK_CYCLES     = (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage
`default_nettype wire

/* hdl/pcd_timer_counter.sv */
/*
 * Pulse counters (down, up, compact up) and delay timers (off-delay,
 * compact off-delay, on-delay) with presets reachable over AXI4-Lite.
 * Assumes boolean inputs come from pins and are synchronised here, and
 * external preset words come from logic on the same clock.
 */
`default_nettype none
// Contract
// - Every counter holds a settable preset of pulses to count before its output goes true.
// - Counters and full timers take their preset from an integer input when it is selected; the compact up counter has only its register preset.
// - The down counter output is 0 while its accumulator is nonzero and 1 when it is zero.
// - Each rising edge of the down counter pulse input decrements its accumulator by one; the code holds the accumulator at zero instead of going below it.
// - While its reset input is true the down counter reloads its count.
// - Each rising edge of the up counter pulse input increments its visible accumulator; the code holds the accumulator at ACC_MAX instead of wrapping.
// - While its reset input is true the up counter clears its accumulator.
// - The up counter output is true once the count has reached the preset.
// - The compact up counter has enable, pulse and one output, with its count kept inside.
// - After its input falls the off-delay timer holds its output true for preset times 10 ms.
// - If the off-delay input returns true first the output stays true and timing restarts.
// - Each falling edge of the off-delay timer input increments its accumulator by one.
// - The compact off-delay timer has one input, one output and only the internal preset.
// - The on-delay timer delays the output rise after its input rise by preset times 10 ms.
module pcd_timer_counter
   import pcd_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic      [1:0]        s_axi_bresp,
   // AXI4-Lite read
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic      [31:0]       s_axi_rdata,
   output logic      [1:0]        s_axi_rresp,
   // Down counter
   input  wire logic              dn_enable,
   input  wire logic              dn_pulse,
   input  wire logic              dn_reset,
   input  wire logic [VAL_W-1:0]  dn_preset_input,
   output logic                   dn_enable_output,
   output logic                   dn_out,
   output logic      [VAL_W-1:0]  dn_pulse_accumulator,
   // Up counter
   input  wire logic              up_enable,
   input  wire logic              up_pulse,
   input  wire logic              up_reset,
   input  wire logic [VAL_W-1:0]  up_preset_input,
   output logic                   up_enable_output,
   output logic                   up_out,
   output logic      [VAL_W-1:0]  up_pulse_accumulator,
   // Compact up counter
   input  wire logic              compact_enable_in,
   input  wire logic              compact_pulse_in,
   output logic                   cu_out,
   // Off-delay timer
   input  wire logic              of_enable,
   input  wire logic              of_in,
   input  wire logic [VAL_W-1:0]  of_preset_input,
   output logic                   of_enable_output,
   output logic                   of_out,
   output logic      [VAL_W-1:0]  of_pulse_accumulator,
   // Compact off-delay timer
   input  wire logic              cof_in,
   output logic                   cof_out,
   // On-delay timer
   input  wire logic              on_enable,
   input  wire logic              on_in,
   input  wire logic [VAL_W-1:0]  on_preset_input,
   output logic                   on_enable_output,
   output logic                   on_out
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Input synchronisation
   logic [NUM_IN-1:0] raw_in;
   logic [NUM_IN-1:0] lvl;
   logic [NUM_IN-1:0] rise;
   logic [NUM_IN-1:0] fall;

   assign raw_in = {on_in, on_enable, cof_in, of_in, of_enable, compact_pulse_in,
                    compact_enable_in, up_reset, up_pulse, up_enable, dn_reset,
                    dn_pulse, dn_enable};

   pcd_in_sync #(.WIDTH(NUM_IN)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .din     (raw_in),
      .level   (lvl),
      .rise    (rise),
      .fall    (fall)
   );

   // Register file state
   logic [3:0]       ctrl_r;
   logic [VAL_W-1:0] preset_r [NUM_PRESET];
   logic             aw_held_r;
   logic [3:0]       aw_idx_r;
   logic             w_held_r;
   logic [31:0]      wdata_r;
   logic [3:0]       wstrb_r;
   logic             bvalid_r;
   logic [1:0]       bresp_r;
   logic             rvalid_r;
   logic [31:0]      rdata_r;
   logic [1:0]       rresp_r;

   // Function state
   logic [VAL_W-1:0] dn_acc_r;
   logic [VAL_W-1:0] up_acc_r;
   logic [VAL_W-1:0] cu_acc_r;
   logic [VAL_W-1:0] of_acc_r   [2];
   logic [VAL_W-1:0] of_hold_r  [2];
   logic             of_timing_r[2];
   logic             of_out_r   [2];
   logic [VAL_W-1:0] on_cnt_r;
   logic             on_out_r;
   logic [31:0]      tick_cnt_r;
   logic             tick;

   // Effective presets
   wire  [VAL_W-1:0] dn_pv = ctrl_r[CTRL_DN_EXT] ? dn_preset_input : preset_r[PS_DN];
   wire  [VAL_W-1:0] up_pv = ctrl_r[CTRL_UP_EXT] ? up_preset_input : preset_r[PS_UP];
   wire  [VAL_W-1:0] of_pv = ctrl_r[CTRL_OF_EXT] ? of_preset_input : preset_r[PS_OF];
   wire  [VAL_W-1:0] on_pv = ctrl_r[CTRL_ON_EXT] ? on_preset_input : preset_r[PS_ON];
   wire  [VAL_W-1:0] lane_pv  [2];
   wire              lane_en  [2];
   wire              lane_in  [2];
   wire              lane_fall[2];

   assign lane_pv[0]   = of_pv;
   assign lane_pv[1]   = preset_r[PS_COF];
   assign lane_en[0]   = lvl[IN_OF_EN];
   assign lane_en[1]   = 1'b1;
   assign lane_in[0]   = lvl[IN_OF_IN];
   assign lane_in[1]   = lvl[IN_COF_IN];
   assign lane_fall[0] = fall[IN_OF_IN];
   assign lane_fall[1] = fall[IN_COF_IN];

   // Write address and data are taken independently, in either order
   wire [3:0] aw_idx   = s_axi_awaddr[5:2];
   wire [3:0] ar_idx   = s_axi_araddr[5:2];
   wire       aw_hs    = s_axi_awvalid & ~aw_held_r;
   wire       w_hs     = s_axi_wvalid & ~w_held_r;
   wire       do_wr    = aw_held_r & w_held_r & ~bvalid_r;
   wire       ar_hs    = s_axi_arvalid & ~rvalid_r;
   wire       wr_ctrl  = aw_idx_r == OFS_CTRL[5:2];
   wire       wr_pre   = aw_idx_r >= OFS_PRESET_BASE[5:2] &&
                         aw_idx_r < OFS_STATUS[5:2];
   wire [3:0] wr_slot  = aw_idx_r - OFS_PRESET_BASE[5:2];
   wire       wr_ro    = aw_idx_r == OFS_STATUS[5:2] || aw_idx_r == OFS_DN_ACC[5:2] ||
                         aw_idx_r == OFS_UP_ACC[5:2] || aw_idx_r == OFS_OF_ACC[5:2];
   wire       wr_hit   = wr_ctrl | wr_pre | wr_ro;

   wire [31:0] status_word = {20'h0, lvl[IN_ON_EN], lvl[IN_OF_EN], lvl[IN_UP_EN],
                              lvl[IN_DN_EN], 2'h0, on_out, cof_out, of_out, cu_out,
                              up_out, dn_out};
   wire        rd_pre      = ar_idx >= OFS_PRESET_BASE[5:2] && ar_idx < OFS_STATUS[5:2];
   wire [3:0]  rd_slot     = ar_idx - OFS_PRESET_BASE[5:2];
   wire        rd_hit      = rd_pre || ar_idx == OFS_CTRL[5:2] ||
                             ar_idx == OFS_STATUS[5:2] || ar_idx == OFS_DN_ACC[5:2] ||
                             ar_idx == OFS_UP_ACC[5:2] || ar_idx == OFS_OF_ACC[5:2];
   wire [31:0] rd_data     =
      (ar_idx == OFS_CTRL[5:2])   ? {28'h0, ctrl_r} :
      rd_pre                      ? {16'h0, preset_r[rd_slot[2:0]]} :
      (ar_idx == OFS_STATUS[5:2]) ? status_word :
      (ar_idx == OFS_DN_ACC[5:2]) ? {16'h0, dn_acc_r} :
      (ar_idx == OFS_UP_ACC[5:2]) ? {16'h0, up_acc_r} :
      (ar_idx == OFS_OF_ACC[5:2]) ? {of_acc_r[1], of_acc_r[0]} : 32'h0;

   function automatic logic [VAL_W-1:0] merge16(input logic [VAL_W-1:0] old,
                                                input logic [31:0]      data,
                                                input logic [3:0]       strb);
      merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
   endfunction

   // Bus slave
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         aw_idx_r  <= 4'h0;
         w_held_r  <= 1'b0;
         wdata_r   <= 32'h0;
         wstrb_r   <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0;
         rresp_r   <= RESP_OKAY;
      end else begin
         if (aw_hs) begin
            aw_held_r <= 1'b1;
            aw_idx_r  <= aw_idx;
         end else if (do_wr) begin
            aw_held_r <= 1'b0;
         end
         if (w_hs) begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end else if (do_wr) begin
            w_held_r <= 1'b0;
         end
         if (do_wr) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
         if (ar_hs) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_data;
            rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= CTRL_RST;
         for (int i = 0; i < NUM_PRESET; i++) begin
            preset_r[i] <= PRESET_RST;
         end
      end else if (do_wr) begin
         if (wr_ctrl && wstrb_r[0]) begin
            ctrl_r <= wdata_r[3:0];
         end
         if (wr_pre) begin
            preset_r[wr_slot[2:0]] <= merge16(preset_r[wr_slot[2:0]], wdata_r, wstrb_r);
         end
      end
   end

   assign s_axi_awready = ~aw_held_r;
   assign s_axi_wready  = ~w_held_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   // 10 ms time base
   always_ff @(posedge aclk) begin
      if (!aresetn || tick) begin
         tick_cnt_r <= 32'h0;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h1;
      end
   end
   assign tick = tick_cnt_r == 32'(TICK_CYC - 1);

   // Counters
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dn_acc_r <= PRESET_RST;
         up_acc_r <= 16'h0;
         cu_acc_r <= 16'h0;
      end else begin
         if (lvl[IN_DN_RST]) begin
            dn_acc_r <= dn_pv;
         end else if (lvl[IN_DN_EN] && rise[IN_DN_PULSE] && dn_acc_r != 16'h0) begin
            dn_acc_r <= dn_acc_r - 16'h1;
         end
         if (lvl[IN_UP_RST]) begin
            up_acc_r <= 16'h0;
         end else if (lvl[IN_UP_EN] && rise[IN_UP_PULSE] && up_acc_r != ACC_MAX) begin
            up_acc_r <= up_acc_r + 16'h1;
         end
         if (lvl[IN_CU_EN] && rise[IN_CU_PULSE] && cu_acc_r != ACC_MAX) begin
            cu_acc_r <= cu_acc_r + 16'h1;
         end
      end
   end

   assign dn_out = dn_acc_r == 16'h0;
   assign up_out = up_acc_r >= up_pv;
   assign cu_out = cu_acc_r >= preset_r[PS_CU];

   // Off-delay lanes: 0 full timer, 1 compact timer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 2; i++) begin
            of_acc_r[i]    <= 16'h0;
            of_hold_r[i]   <= 16'h0;
            of_timing_r[i] <= 1'b0;
            of_out_r[i]    <= 1'b0;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (lane_en[i]) begin
               if (lane_in[i]) begin
                  of_out_r[i]    <= 1'b1;
                  of_timing_r[i] <= 1'b0;
                  of_hold_r[i]   <= 16'h0;
               end else if (lane_fall[i]) begin
                  of_acc_r[i]    <= of_acc_r[i] + 16'h1;
                  of_hold_r[i]   <= 16'h0;
                  of_timing_r[i] <= lane_pv[i] != 16'h0;
                  of_out_r[i]    <= lane_pv[i] != 16'h0;
               end else if (of_timing_r[i] && tick) begin
                  of_hold_r[i] <= of_hold_r[i] + 16'h1;
                  if (of_hold_r[i] + 16'h1 >= lane_pv[i]) begin
                     of_out_r[i]    <= 1'b0;
                     of_timing_r[i] <= 1'b0;
                  end
               end
            end
         end
      end
   end

   assign of_out               = of_out_r[0];
   assign cof_out              = of_out_r[1];
   assign of_pulse_accumulator = of_acc_r[0];

   // On-delay timer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         on_cnt_r <= 16'h0;
         on_out_r <= 1'b0;
      end else if (lvl[IN_ON_EN]) begin
         if (!lvl[IN_ON_IN]) begin
            on_cnt_r <= 16'h0;
            on_out_r <= 1'b0;
         end else if (!on_out_r && on_pv == 16'h0) begin
            on_out_r <= 1'b1;
         end else if (!on_out_r && tick) begin
            on_cnt_r <= on_cnt_r + 16'h1;
            on_out_r <= on_cnt_r + 16'h1 >= on_pv;
         end
      end
   end

   assign on_out               = on_out_r;
   assign dn_pulse_accumulator = dn_acc_r;
   assign up_pulse_accumulator = up_acc_r;
   assign dn_enable_output     = lvl[IN_DN_EN];
   assign up_enable_output     = lvl[IN_UP_EN];
   assign of_enable_output     = lvl[IN_OF_EN];
   assign on_enable_output     = lvl[IN_ON_EN];

   // Checks
   chk_dn_decrement: assert property (
      lvl[IN_DN_EN] && rise[IN_DN_PULSE] && !lvl[IN_DN_RST] && dn_acc_r != 16'h0
      |=> dn_acc_r == $past(dn_acc_r) - 16'h1)
      else $error("down counter did not decrement on a pulse");
   chk_dn_reload: assert property (
      lvl[IN_DN_RST] |=> dn_acc_r == $past(dn_pv) && (dn_out == ($past(dn_pv) == 16'h0)))
      else $error("down counter did not reload under reset");
   chk_up_clear: assert property (
      lvl[IN_UP_RST] |=> up_acc_r == 16'h0)
      else $error("up counter not cleared under reset");
   chk_up_count: assert property (
      !lvl[IN_UP_RST] && (!lvl[IN_UP_EN] || !rise[IN_UP_PULSE]) |=> $stable(up_acc_r))
      else $error("up counter moved without an enabled pulse");
   chk_cu_count: assert property (
      lvl[IN_CU_EN] && rise[IN_CU_PULSE] && cu_acc_r != ACC_MAX
      |=> cu_acc_r == $past(cu_acc_r) + 16'h1)
      else $error("compact up counter missed a pulse");
   chk_of_hold: assert property (
      lane_en[0] && lane_fall[0] && lane_pv[0] != 16'h0
      |=> of_out && of_hold_r[0] == 16'h0 && of_pulse_accumulator == $past(of_acc_r[0]) + 16'h1)
      else $error("off-delay output dropped or count wrong at falling input");
   chk_of_retrig: assert property (
      lane_en[0] && lane_in[0] |=> of_out ##0 !of_timing_r[0])
      else $error("off-delay output not true while input is true");
   chk_on_low: assert property (
      lvl[IN_ON_EN] && !lvl[IN_ON_IN] |=> !on_out && on_cnt_r == 16'h0)
      else $error("on-delay output true with input false");
   chk_on_rise: assert property (
      lvl[IN_ON_EN] && lvl[IN_ON_IN] && !on_out_r && on_pv != 16'h0 && !tick |=> !on_out)
      else $error("on-delay output rose between ticks");
   chk_wr_resp: assert property (
      do_wr |=> s_axi_bvalid && !aw_held_r && !w_held_r)
      else $error("write response not raised after address and data");
   chk_rd_resp: assert property (
      ar_hs |=> s_axi_rvalid && s_axi_rdata == $past(rd_data))
      else $error("read data not returned one cycle after address");
endmodule
`default_nettype wire

/* sim/pcd_fb_src.sv */
/*
 * Model of a neighbouring function block that feeds a preset word.
 * Assumes the same clock as the block under test.
 */
`default_nettype none
module pcd_fb_src (
   // Clock
   input  wire logic        aclk,
   // Load request
   input  wire logic        load,
   input  wire logic [15:0] val,
   // Preset word out
   output var logic  [15:0] word
);
   timeunit 1ns;
   timeprecision 1ns;
   initial word = 16'h0000;
   // Holds the last loaded word steady for the preset input
   always @(posedge aclk) if (load) word <= val;
endmodule
`default_nettype wire

/* sim/pulse_counter_delay_timer_bench.sv */
/*
 * Self-checking bench for the counters and delay timers.
 * Assumes a short time base of 4 clocks and an AXI4-Lite master here.
 */
`default_nettype none
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin failures++; \
   $display("wrong value at %0t: %s", $time, m); end end
module pulse_counter_delay_timer_bench
   import pcd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, ld, t;
   logic [5:0]  awa, ara, pin;
   logic [31:0] wd, rd, d, seed;
   logic [1:0]  bresp, rresp, r, rs;
   logic [4:0]  en;
   logic [15:0] ldv, ext, dn_a, up_a, of_a;
   logic        dn_eo, dn_o, up_eo, up_o, cu_o, of_eo, of_o, cof_o, on_eo, on_o;
   int          failures, compares, cyc, p, dn_m, up_m;
   pcd_fb_src u_pcd_fb_src (.aclk(aclk), .load(ld), .val(ldv), .word(ext));
   pcd_timer_counter #(.TICK_CYC(4)) u_pcd_timer_counter (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd),
      .s_axi_rresp(rresp), .dn_enable(en[0]), .dn_pulse(pin[0]), .dn_reset(rs[0]),
      .dn_preset_input(ext), .dn_enable_output(dn_eo), .dn_out(dn_o),
      .dn_pulse_accumulator(dn_a), .up_enable(en[1]), .up_pulse(pin[1]), .up_reset(rs[1]),
      .up_preset_input(ext), .up_enable_output(up_eo), .up_out(up_o),
      .up_pulse_accumulator(up_a), .compact_enable_in(en[2]), .compact_pulse_in(pin[2]),
      .cu_out(cu_o), .of_enable(en[3]), .of_in(pin[3]), .of_preset_input(ext),
      .of_enable_output(of_eo), .of_out(of_o), .of_pulse_accumulator(of_a),
      .cof_in(pin[4]), .cof_out(cof_o), .on_enable(en[4]), .on_in(pin[5]),
      .on_preset_input(ext), .on_enable_output(on_eo), .on_out(on_o));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic results();
      $display("counts: %0d compares, %0d failures", compares, failures);
      if (failures == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic axw(input logic [5:0] a, input logic [31:0] v);
      logic da, dw;
      da = 0;
      dw = 0;
      @(posedge aclk);
      awv <= 1; awa <= a; wv <= 1; wd <= v; br <= 1;
      while (!(da && dw)) begin
         @(negedge aclk); da |= awr; dw |= wr;
         @(posedge aclk); if (da) awv <= 0; if (dw) wv <= 0;
      end
      do begin @(negedge aclk); t = bv; r = bresp; @(posedge aclk); end while (!t);
      br <= 0;
   endtask
   task automatic axr(input logic [5:0] a);
      @(posedge aclk);
      arv <= 1; ara <= a; rr <= 1;
      do begin @(negedge aclk); t = arr; @(posedge aclk); end while (!t);
      arv <= 0;
      do begin @(negedge aclk); t = rv; d = rd; r = rresp; @(posedge aclk); end while (!t);
      rr <= 0;
   endtask
   // Pulses held 3 clocks each way so the synchroniser sees them
   task automatic pl(input int b, input int k);
      @(posedge aclk);
      repeat (k) begin
         pin[b] <= 1; repeat (3) @(posedge aclk);
         pin[b] <= 0; repeat (3) @(posedge aclk);
      end
      repeat (3) @(posedge aclk);
      @(negedge aclk);
   endtask
   initial begin aclk = 0; forever #5 aclk = ~aclk; end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 6000) begin failures++; results(); end
   end
   initial begin
      {aresetn, awv, wv, br, arv, rr, ld, pin, rs, awa, ara, wd, ldv} = '0;
      en = 5'h1f;
      seed = 32'h7b84;
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      axr(OFS_PRESET_BASE); `CHK(d, 32'h0000000a, "preset reset")
      axr(6'h3c); `CHK(r, RESP_SLVERR, "unmapped resp") `CHK(d, 32'h0, "unmapped data")
      $display("test registers done");
      p = 2 + int'(xs() % 4);
      axw(OFS_PRESET_BASE, p);
      rs[0] <= 1; repeat (4) @(posedge aclk); rs[0] <= 0; @(negedge aclk);
      dn_m = p; `CHK(dn_a, dn_m[15:0], "down reload")
      pl(0, p - 1); dn_m -= p - 1; `CHK(dn_a, dn_m[15:0], "down count")
      `CHK(dn_o, 1'b0, "down out early")
      pl(0, 2); `CHK(dn_a, 16'h0, "down floor") `CHK(dn_o, 1'b1, "down out")
      $display("test down counter done");
      p = 2 + int'(xs() % 5);
      @(posedge aclk); ldv <= p[15:0]; ld <= 1; @(posedge aclk); ld <= 0;
      axw(OFS_CTRL, 32'h2);
      pl(1, p - 1); up_m = p - 1; `CHK(up_a, up_m[15:0], "up count")
      `CHK(up_o, 1'b0, "up out early")
      @(posedge aclk); en[1] <= 0;
      pl(1, 2); `CHK(up_a, up_m[15:0], "up frozen") `CHK(up_eo, 1'b0, "up enable copy")
      @(posedge aclk); en[1] <= 1;
      pl(1, 1); up_m++; `CHK(up_a, up_m[15:0], "up ext count")
      `CHK(up_o, 1'b1, "up out")
      @(posedge aclk); rs[1] <= 1; repeat (5) @(posedge aclk); rs[1] <= 0; @(negedge aclk);
      `CHK(up_a, 16'h0, "up clear")
      $display("test up counter done");
      for (int i = 2; i < 6; i++) axw(OFS_PRESET_BASE + 6'(4 * i), 32'h3);
      pl(2, 2); `CHK(cu_o, 1'b0, "compact early")
      pl(2, 1); `CHK(cu_o, 1'b1, "compact out")
      for (int b = 3; b < 5; b++) begin
         @(posedge aclk); pin[b] <= 1; repeat (5) @(posedge aclk); pin[b] <= 0;
         repeat (6) @(posedge aclk); @(negedge aclk);
         `CHK((b == 3) ? of_o : cof_o, 1'b1, "hold active")
         repeat (12) @(posedge aclk); @(negedge aclk);
         `CHK((b == 3) ? of_o : cof_o, 1'b0, "hold over")
      end
      `CHK(of_a, 16'h1, "off falls")
      @(posedge aclk); pin[5] <= 1; repeat (6) @(posedge aclk); @(negedge aclk);
      `CHK(on_o, 1'b0, "on delay early")
      repeat (12) @(posedge aclk); @(negedge aclk);
      `CHK(on_o, 1'b1, "on delay out")
      $display("test timers done");
      `CHK({dn_eo, of_eo, on_eo}, 3'h7, "enable copies")
      axr(OFS_STATUS); `CHK(d, 32'h00000f25, "status word")
      axr(OFS_OF_ACC); `CHK(d, 32'h00010001, "off-delay counts")
      @(posedge aclk); ldv <= 16'h7; ld <= 1; @(posedge aclk); ld <= 0;
      axw(OFS_CTRL, 32'h1); `CHK(r, RESP_OKAY, "write resp")
      rs[0] <= 1; repeat (4) @(posedge aclk); rs[0] <= 0; @(negedge aclk);
      `CHK(dn_a, 16'h7, "down ext reload")
      $display("test readback done");
      results();
   end
endmodule
`default_nettype wire
